// ===== design/track_diag_consts.svh
// Constants of the repeated track read diagnostic
`ifndef TRACK_DIAG_CONSTS_SVH
`define TRACK_DIAG_CONSTS_SVH

// ==================================================
// Timing
`define CLK_HZ          25000000
`define IDX_WAIT_MS     18
`define RDY_WAIT_S      1
`define SEQ_WAIT_S      30
`define OFS_WAIT_MS     200
`define RECAL_DROP_US   10
`define IDX_WAIT_CYC    (`IDX_WAIT_MS * (`CLK_HZ / 1000))
`define RDY_WAIT_CYC    (`RDY_WAIT_S * `CLK_HZ)
`define SEQ_WAIT_CYC    (`SEQ_WAIT_S * `CLK_HZ)
`define OFS_WAIT_CYC    (`OFS_WAIT_MS * (`CLK_HZ / 1000))
`define RECAL_DROP_CYC  (`RECAL_DROP_US * (`CLK_HZ / 1000000))

// ==================================================
// Register addresses
`define A_CYL_HI        8'h00
`define A_CYL_LO        8'h01
`define A_HEAD          8'h02
`define A_PATTERN       8'h03
`define A_OFFSET        8'h04
`define A_TRIES_HI      8'h08
`define A_TRIES_LO      8'h09
`define A_ERRS_HI       8'h0A
`define A_ERRS_LO       8'h0B
`define A_CTRL          8'h10
`define A_CODE          8'h11

// ==================================================
// Fields, limits and reset values
`define CTRL_START_BIT  0
`define CYL_HI_MAX      8'h03
`define HEAD_MAX        8'h12
`define OFFSET_MAX      8'h1F
`define PARAM_RST       8'h00
`define PATTERN_RST     8'hDB
`define TRIES_FULL      16'hFFFF
`define COUNT_ZERO      16'h0000
`define ONE16           16'h0001
`define TIMER_ZERO      32'h0000_0000
`define TIMER_ONE       32'h0000_0001

// ==================================================
// Completion and error codes
`define C_NONE          8'h00
`define C_PARAM         8'h01
`define C_NO_INDEX      8'h02
`define C_UNSAFE        8'h03
`define C_READ_ERR      8'h04
`define C_NOT_ONLINE    8'hA1
`define C_NOT_READY     8'hA2
`define C_STILL_READY   8'hA3
`define C_SEEK_INC      8'hA4
`define C_RDY_TIMEOUT   8'hA5
`define C_SEQ_TIMEOUT   8'hA6
`define C_OFS_TIMEOUT   8'hA7
`define C_SUCCESS       8'hFF

`endif

// ===== design/track_diag_pkg.sv
// Types of the repeated track read diagnostic
package track_diag_pkg;

  // ==================================================
  // Sequencer states
  typedef enum logic [12:0] {
    ST_IDLE     = 13'b0_0000_0000_0001,
    ST_CHECK    = 13'b0_0000_0000_0010,
    ST_SEQWAIT  = 13'b0_0000_0000_0100,
    ST_RECAL    = 13'b0_0000_0000_1000,
    ST_RECDROP  = 13'b0_0000_0001_0000,
    ST_RECRDY   = 13'b0_0000_0010_0000,
    ST_SEEK     = 13'b0_0000_0100_0000,
    ST_SEEKRDY  = 13'b0_0000_1000_0000,
    ST_OFFSET   = 13'b0_0001_0000_0000,
    ST_OFSRDY   = 13'b0_0010_0000_0000,
    ST_IDXWAIT  = 13'b0_0100_0000_0000,
    ST_READ     = 13'b0_1000_0000_0000,
    ST_DONE     = 13'b1_0000_0000_0000
  } seqState_e;

  // ==================================================
  // Drive status lines
  typedef struct packed {
    logic online;
    logic ready;
    logic index;
    logic unsafe;
    logic seekInc;
    logic offsetRdy;
    logic readDone;
    logic readErr;
  } driveIn_s;

  // ==================================================
  // Drive commands and target
  typedef struct packed {
    logic       recal;
    logic       seek;
    logic       offset;
    logic       offsetReset;
    logic       read;
    logic [9:0] cyl;
    logic [7:0] head;
    logic [7:0] offsetVal;
  } driveCmd_s;

endpackage

// ===== design/track_read_diag.sv
// Repeated track read diagnostic sequencer
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "track_diag_consts.svh"
// Functional notes
// - Check head, cylinder and offset bytes (offset 00-1F); end with 01 if bad.
// - With no explicit selection, target head 00 on cylinder 000.
// - Wait for index at most 18 ms; end with code 02 otherwise.
// - Unsafe during the repeated reads stops the run with code 03.
// - Read error gives 04; bytes 08/09 attempts, 0A/0B errors.
// - Attempt counter allows 65535 reads; zero marks normal completion.
// - Run switch ends early; attempt counter keeps a nonzero remainder.
// - Drive not online before recalibrate ends with code A1.
// - Drive not ready before recalibrate ends with code A2.
// - Ready still asserted after recalibrate issued ends with code A3.
// - Not ready within one second after recalibrate or seek ends with A5.
// - Not online and ready within 30 s after sequencing up ends with A6.
// - No offset ready within 200 ms after offset command ends with A7.

module track_read_diag
  import track_diag_pkg::*;
#(
  parameter logic [31:0] IDX_WAIT_CYC = `IDX_WAIT_CYC,
  parameter logic [31:0] RDY_WAIT_CYC = `RDY_WAIT_CYC,
  parameter logic [31:0] SEQ_WAIT_CYC = `SEQ_WAIT_CYC,
  parameter logic [31:0] OFS_WAIT_CYC = `OFS_WAIT_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  input  wire logic       runSwitch,
  input  wire driveIn_s   driveIn,
  output driveCmd_s       driveCmd,
  output logic            busy,
  output logic      [7:0] resultCode
);

  // ==================================================
  // Helpers
  function automatic logic paramsValid(input logic [7:0] cylHi, input logic [7:0] head,
                                       input logic [7:0] ofs);
    paramsValid = (cylHi <= `CYL_HI_MAX) && (head <= `HEAD_MAX) && (ofs <= `OFFSET_MAX);
  endfunction

  function automatic logic [31:0] tick(input logic [31:0] t);
    tick = (t == `TIMER_ZERO) ? `TIMER_ZERO : t - `TIMER_ONE;
  endfunction

  // ==================================================
  // Input synchronisers
  driveIn_s  drvMeta_r;
  driveIn_s  drv_r;
  logic      runMeta_r;
  logic      run_r;
  logic      runPrev_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drvMeta_r <= '0;
      drv_r     <= '0;
      runMeta_r <= 1'b0;
      run_r     <= 1'b0;
      runPrev_r <= 1'b0;
    end else begin
      drvMeta_r <= driveIn;
      drv_r     <= drvMeta_r;
      runMeta_r <= runSwitch;
      run_r     <= runMeta_r;
      runPrev_r <= run_r;
    end
  end

  logic runPress;
  assign runPress = run_r && !runPrev_r;

  // ==================================================
  // Parameter bytes and bus read path
  logic [7:0] cylHi_r;
  logic [7:0] cylLo_r;
  logic [7:0] head_r;
  logic [7:0] pattern_r;
  logic [7:0] offset_r;
  logic [7:0] rdata_r;
  logic [7:0] cylHi_nxt;
  logic [7:0] cylLo_nxt;
  logic [7:0] head_nxt;
  logic [7:0] pattern_nxt;
  logic [7:0] offset_nxt;
  logic [7:0] rdata_nxt;
  logic [15:0] tries_r;
  logic [15:0] errs_r;
  logic [7:0]  code_r;
  logic        busy_r;
  logic        paramWr;

  assign paramWr = regWr && !busy_r;

  always_comb begin
    cylHi_nxt   = cylHi_r;
    cylLo_nxt   = cylLo_r;
    head_nxt    = head_r;
    pattern_nxt = pattern_r;
    offset_nxt  = offset_r;
    rdata_nxt   = `PARAM_RST;
    if (paramWr) begin
      case (regAddr)
        `A_CYL_HI:  cylHi_nxt   = regWdata;
        `A_CYL_LO:  cylLo_nxt   = regWdata;
        `A_HEAD:    head_nxt    = regWdata;
        `A_PATTERN: pattern_nxt = regWdata;
        `A_OFFSET:  offset_nxt  = regWdata;
        default:    ;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        `A_CYL_HI:   rdata_nxt = cylHi_r;
        `A_CYL_LO:   rdata_nxt = cylLo_r;
        `A_HEAD:     rdata_nxt = head_r;
        `A_PATTERN:  rdata_nxt = pattern_r;
        `A_OFFSET:   rdata_nxt = offset_r;
        `A_TRIES_HI: rdata_nxt = tries_r[15:8];
        `A_TRIES_LO: rdata_nxt = tries_r[7:0];
        `A_ERRS_HI:  rdata_nxt = errs_r[15:8];
        `A_ERRS_LO:  rdata_nxt = errs_r[7:0];
        `A_CTRL:     rdata_nxt = {7'h00, busy_r};
        `A_CODE:     rdata_nxt = code_r;
        default:     rdata_nxt = `PARAM_RST;
      endcase
    end
  end

  // Reset values select head 00, cylinder 000
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cylHi_r   <= `PARAM_RST;
      cylLo_r   <= `PARAM_RST;
      head_r    <= `PARAM_RST;
      pattern_r <= `PATTERN_RST;
      offset_r  <= `PARAM_RST;
      rdata_r   <= `PARAM_RST;
    end else begin
      cylHi_r   <= cylHi_nxt;
      cylLo_r   <= cylLo_nxt;
      head_r    <= head_nxt;
      pattern_r <= pattern_nxt;
      offset_r  <= offset_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ==================================================
  // Sequencer
  seqState_e  state_r;
  seqState_e  state_nxt;
  logic [31:0] timer_r;
  logic [31:0] timer_nxt;
  logic [15:0] tries_nxt;
  logic [15:0] errs_nxt;
  logic [7:0]  code_nxt;
  logic        busy_nxt;
  driveCmd_s   cmd_r;
  driveCmd_s   cmd_nxt;
  logic        startReq;
  logic        timeout;

  assign startReq = (regWr && regAddr == `A_CTRL && regWdata[`CTRL_START_BIT]) || runPress;
  assign timeout  = (timer_r == `TIMER_ZERO);

  always_comb begin
    state_nxt           = state_r;
    timer_nxt           = tick(timer_r);
    tries_nxt           = tries_r;
    errs_nxt            = errs_r;
    code_nxt            = code_r;
    busy_nxt            = busy_r;
    cmd_nxt             = cmd_r;
    cmd_nxt.recal       = 1'b0;
    cmd_nxt.seek        = 1'b0;
    cmd_nxt.offset      = 1'b0;
    cmd_nxt.offsetReset = 1'b0;
    cmd_nxt.read        = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (startReq) begin
          busy_nxt  = 1'b1;
          code_nxt  = `C_NONE;
          tries_nxt = `TRIES_FULL;
          errs_nxt  = `COUNT_ZERO;
          state_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (!paramsValid(cylHi_r, head_r, offset_r)) begin
          code_nxt  = `C_PARAM;
          state_nxt = ST_DONE;
        end else begin
          cmd_nxt.cyl       = {cylHi_r[1:0], cylLo_r};
          cmd_nxt.head      = head_r;
          cmd_nxt.offsetVal = offset_r;
          timer_nxt         = SEQ_WAIT_CYC;
          state_nxt         = ST_SEQWAIT;
        end
      end
      ST_SEQWAIT: begin
        if (drv_r.online && drv_r.ready) begin
          state_nxt = ST_RECAL;
        end else if (timeout) begin
          code_nxt  = `C_SEQ_TIMEOUT;
          state_nxt = ST_DONE;
        end
      end
      ST_RECAL: begin
        if (!drv_r.online) begin
          code_nxt  = `C_NOT_ONLINE;
          state_nxt = ST_DONE;
        end else if (!drv_r.ready) begin
          code_nxt  = `C_NOT_READY;
          state_nxt = ST_DONE;
        end else begin
          cmd_nxt.recal = 1'b1;
          timer_nxt     = `RECAL_DROP_CYC;
          state_nxt     = ST_RECDROP;
        end
      end
      ST_RECDROP: begin
        if (!drv_r.ready) begin
          timer_nxt = RDY_WAIT_CYC;
          state_nxt = ST_RECRDY;
        end else if (timeout) begin
          code_nxt  = `C_STILL_READY;
          state_nxt = ST_DONE;
        end
      end
      ST_RECRDY, ST_SEEKRDY: begin
        if (drv_r.seekInc) begin
          code_nxt  = `C_SEEK_INC;
          state_nxt = ST_DONE;
        end else if (drv_r.ready && (state_r == ST_RECRDY || timer_r <= RDY_WAIT_CYC - `RECAL_DROP_CYC)) begin
          state_nxt = (state_r == ST_RECRDY) ? ST_SEEK : ST_OFFSET;
        end else if (timeout) begin
          code_nxt  = `C_RDY_TIMEOUT;
          state_nxt = ST_DONE;
        end
      end
      ST_SEEK: begin
        cmd_nxt.seek = 1'b1;
        timer_nxt    = RDY_WAIT_CYC;
        state_nxt    = ST_SEEKRDY;
      end
      ST_OFFSET: begin
        cmd_nxt.offset      = (offset_r != `PARAM_RST);
        cmd_nxt.offsetReset = (offset_r == `PARAM_RST);
        timer_nxt           = OFS_WAIT_CYC;
        state_nxt           = ST_OFSRDY;
      end
      ST_OFSRDY: begin
        if (drv_r.offsetRdy) begin
          timer_nxt = IDX_WAIT_CYC;
          state_nxt = ST_IDXWAIT;
        end else if (timeout) begin
          code_nxt  = `C_OFS_TIMEOUT;
          state_nxt = ST_DONE;
        end
      end
      ST_IDXWAIT, ST_READ: begin
        if (drv_r.unsafe) begin
          code_nxt  = `C_UNSAFE;
          state_nxt = ST_DONE;
        end else if (runPress) begin
          code_nxt  = (errs_r != `COUNT_ZERO) ? `C_READ_ERR : `C_SUCCESS;
          state_nxt = ST_DONE;
        end else if (state_r == ST_IDXWAIT) begin
          if (drv_r.index) begin
            cmd_nxt.read = 1'b1;
            timer_nxt    = IDX_WAIT_CYC;
            state_nxt    = ST_READ;
          end else if (timeout) begin
            code_nxt  = `C_NO_INDEX;
            state_nxt = ST_DONE;
          end
        end else if (drv_r.readDone) begin
          tries_nxt = tries_r - `ONE16;
          if (drv_r.readErr) begin
            errs_nxt = errs_r + `ONE16;
          end
          timer_nxt = IDX_WAIT_CYC;
          if (tries_r == `ONE16) begin
            code_nxt  = (drv_r.readErr || errs_r != `COUNT_ZERO) ? `C_READ_ERR : `C_SUCCESS;
            state_nxt = ST_DONE;
          end else begin
            state_nxt = ST_IDXWAIT;
          end
        end else if (timeout) begin
          code_nxt  = `C_NO_INDEX;
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        busy_nxt  = 1'b0;
        state_nxt = ST_IDLE;
      end
      default: begin
        busy_nxt  = 1'b0;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      timer_r <= `TIMER_ZERO;
      tries_r <= `COUNT_ZERO;
      errs_r  <= `COUNT_ZERO;
      code_r  <= `C_NONE;
      busy_r  <= 1'b0;
      cmd_r   <= '0;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      tries_r <= tries_nxt;
      errs_r  <= errs_nxt;
      code_r  <= code_nxt;
      busy_r  <= busy_nxt;
      cmd_r   <= cmd_nxt;
    end
  end

  assign regRdata   = rdata_r;
  assign driveCmd   = cmd_r;
  assign busy       = busy_r;
  assign resultCode = code_r;

endmodule

// ===== tb/track_read_diag_asserts.sv
// Port assertions for the track read diagnostic
`timescale 1ns/100ps
module track_read_diag_asserts
  import track_diag_pkg::*;
#(
  parameter logic [31:0] IDX_WAIT_CYC = 32'h0000_0001,
  parameter logic [31:0] RDY_WAIT_CYC = 32'h0000_0001,
  parameter logic [31:0] SEQ_WAIT_CYC = 32'h0000_0001,
  parameter logic [31:0] OFS_WAIT_CYC = 32'h0000_0001
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic       runSwitch,
  input wire driveIn_s   driveIn,
  input wire driveCmd_s  driveCmd,
  input wire logic       busy,
  input wire logic [7:0] resultCode
);
  // ==========
  // Run history
  logic readSeen_r;
  logic errSeen_r;
  logic readSeen_nxt;
  logic errSeen_nxt;
  logic [7:0] cylHiSh_r;
  logic [7:0] headSh_r;
  logic [7:0] ofsSh_r;
  logic [7:0] cylHiSh_nxt;
  logic [7:0] headSh_nxt;
  logic [7:0] ofsSh_nxt;

  // Shadow of the cylinder-high, head and offset bytes, written only while idle
  always_comb begin
    readSeen_nxt = busy && (readSeen_r || driveCmd.read);
    errSeen_nxt  = busy && (errSeen_r || (readSeen_r && driveIn.readErr));
    cylHiSh_nxt  = cylHiSh_r;
    headSh_nxt   = headSh_r;
    ofsSh_nxt    = ofsSh_r;
    if (regWr && !busy) begin
      case (regAddr)
        8'h00:   cylHiSh_nxt = regWdata;
        8'h02:   headSh_nxt  = regWdata;
        8'h04:   ofsSh_nxt   = regWdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      readSeen_r <= 1'b0;
      errSeen_r  <= 1'b0;
      cylHiSh_r  <= 8'h00;
      headSh_r   <= 8'h00;
      ofsSh_r    <= 8'h00;
    end else begin
      readSeen_r <= readSeen_nxt;
      errSeen_r  <= errSeen_nxt;
      cylHiSh_r  <= cylHiSh_nxt;
      headSh_r   <= headSh_nxt;
      ofsSh_r    <= ofsSh_nxt;
    end
  end

  // ==========
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  AST_PARAM_CODE: assert property (
    $rose(busy) && (cylHiSh_r > 8'h03 || headSh_r > 8'h12 || ofsSh_r > 8'h1F) |-> ##1 resultCode == 8'h01)
    else $error("bad parameter run did not end with code 01");
  AST_PARAM_PASS: assert property (
    $rose(busy) && cylHiSh_r <= 8'h03 && headSh_r <= 8'h12 && ofsSh_r <= 8'h1F |-> ##1 resultCode != 8'h01)
    else $error("valid parameters rejected with code 01");
  AST_RECAL_GUARD: assert property (
    driveCmd.recal |-> $past(driveIn.online, 3) && $past(driveIn.ready, 3))
    else $error("recalibrate issued while drive offline or not ready");
  AST_CMD_PULSE: assert property (
    driveCmd.recal || driveCmd.seek |=> !driveCmd.recal && !driveCmd.seek)
    else $error("positioning command longer than one cycle");
  AST_UNSAFE_STOP: assert property (
    readSeen_r && driveIn.unsafe |-> ##[1:8] resultCode == 8'h03)
    else $error("unsafe during reads did not end with code 03");
  AST_ERR_CODE: assert property (
    $fell(busy) && errSeen_r && resultCode inside {8'hFF, 8'h04} |-> resultCode == 8'h04)
    else $error("run with read errors not reported as 04");
  AST_CLEAN_CODE: assert property (
    $fell(busy) && readSeen_r && !errSeen_r && resultCode inside {8'hFF, 8'h04} |-> resultCode == 8'hFF)
    else $error("clean run not reported as FF");
  AST_OFS_KIND: assert property (
    driveCmd.offset || driveCmd.offsetReset |-> driveCmd.offset == (driveCmd.offsetVal != 8'h00))
    else $error("offset command kind does not match offset value");
  AST_CODE_END: assert property (
    busy && resultCode != 8'h00 |=> !busy)
    else $error("busy stayed high after a code was set");
  AST_IDLE_QUIET: assert property (
    !busy |-> !driveCmd.read && !driveCmd.recal && !driveCmd.seek)
    else $error("drive command issued while idle");
endmodule

bind track_read_diag track_read_diag_asserts #(
  .IDX_WAIT_CYC(IDX_WAIT_CYC),
  .RDY_WAIT_CYC(RDY_WAIT_CYC),
  .SEQ_WAIT_CYC(SEQ_WAIT_CYC),
  .OFS_WAIT_CYC(OFS_WAIT_CYC)
) checker_i (.core_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .runSwitch, .driveIn,
  .driveCmd, .busy, .resultCode);

// ===== tb/drive_model.sv
// Behavioural disc drive status model
`timescale 1ns/100ps
module drive_model
  import track_diag_pkg::*;
(
  input  wire logic       core_clk,
  input  wire driveCmd_s  driveCmd,
  input  wire logic [7:0] faults,
  output driveIn_s        driveIn
);
  // Faults: 0 offline, 1 ready never returns, 2 ready never drops, 3 seek incomplete,
  // 4 no index, 5 unsafe, 6 read errors, 7 no offset ready
  logic [7:0] rdyCnt_r = 8'h00;
  logic [7:0] rdCnt_r  = 8'h00;
  logic [3:0] idxCnt_r = 4'h0;
  logic [3:0] ofsCnt_r = 4'h0;
  logic       ofsArm_r = 1'b0;

  always @(posedge core_clk) begin
    idxCnt_r <= idxCnt_r + 4'h1;
    if (driveCmd.recal || driveCmd.seek) begin
      rdyCnt_r <= 8'h14;
    end else if (rdyCnt_r > {7'h00, faults[1]}) begin
      rdyCnt_r <= rdyCnt_r - 8'h01;
    end
    if (driveCmd.recal) begin
      ofsArm_r <= 1'b0;
    end else if (driveCmd.offset || driveCmd.offsetReset) begin
      ofsArm_r <= 1'b1;
      ofsCnt_r <= 4'hA;
    end else if (ofsCnt_r != 4'h0) begin
      ofsCnt_r <= ofsCnt_r - 4'h1;
    end
    if (driveCmd.read) begin
      rdCnt_r <= 8'h06;
    end else if (rdCnt_r != 8'h00) begin
      rdCnt_r <= rdCnt_r - 8'h01;
    end
  end

  always_comb begin
    driveIn.online    = !faults[0];
    driveIn.ready     = faults[2] || rdyCnt_r == 8'h00;
    driveIn.index     = !faults[4] && idxCnt_r[3:1] == 3'h0;
    driveIn.unsafe    = faults[5];
    driveIn.seekInc   = faults[3];
    driveIn.offsetRdy = !faults[7] && ofsArm_r && ofsCnt_r == 4'h0;
    driveIn.readDone  = rdCnt_r == 8'h02 || rdCnt_r == 8'h01;
    driveIn.readErr   = faults[6] && driveIn.readDone;
  end
endmodule

// ===== tb/repeated_track_read_diagnostic_bench.sv
// Self-checking bench for the track read diagnostic
`timescale 1ns/100ps
module repeated_track_read_diagnostic_bench
  import track_diag_pkg::*;
;
  logic       core_clk  = 1'b0;
  logic       rst_n     = 1'b0;
  logic [7:0] regAddr   = 8'h00;
  logic [7:0] regWdata  = 8'h00;
  logic       regWr     = 1'b0;
  logic       regRd     = 1'b0;
  logic       runSwitch = 1'b0;
  logic [7:0] faults    = 8'h00;
  logic [7:0] regRdata;
  driveIn_s   driveIn;
  driveCmd_s  driveCmd;
  logic       busy;
  logic [7:0] resultCode;
  int         bad_count    = 0;
  int         total_checks = 0;

  always #20 core_clk = ~core_clk;

  track_read_diag #(.IDX_WAIT_CYC(32'h0000_012C), .RDY_WAIT_CYC(32'h0000_01F4), .SEQ_WAIT_CYC(32'h0000_01F4),
    .OFS_WAIT_CYC(32'h0000_012C)) dut (.core_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .runSwitch, .driveIn, .driveCmd, .busy, .resultCode);
  drive_model partner (.core_clk, .driveCmd, .faults, .driveIn);

  // ==========
  // Shared tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic timeout();
    chk("wait bound", 16'h0000, 16'h0001);
    tally_and_finish();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge core_clk);
    regWr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd   <= 1'b0;
    @(negedge core_clk);
    d = regRdata;
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 3000) timeout();
  endtask

  task automatic run_expect(input logic [7:0] f, input logic [7:0] code);
    logic [7:0] d;
    @(posedge core_clk);
    faults <= f;
    wr(8'h10, 8'h01);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(8'h11, d);
    chk("code", {resultCode, d}, {code, code});
    faults <= 8'h00;
  endtask

  // ==========
  // Scenarios
  task automatic reset_check();
    logic [7:0] d [3];
    rd(8'h03, d[0]);
    rd(8'h02, d[1]);
    rd(8'h20, d[2]);
    chk("pattern", {8'h00, d[0]}, 16'h00DB);
    chk("head", {d[1], d[2]}, 16'h0000);
  endtask

  task automatic param_runs();
    logic [7:0] a [3] = '{8'h04, 8'h02, 8'h00};
    logic [7:0] v [3] = '{8'h20, 8'h13, 8'h04};
    for (int i = 0; i < 3; i++) begin
      wr(a[i], v[i]);
      run_expect(8'h00, 8'h01);
      wr(a[i], 8'h00);
    end
  endtask

  task automatic fault_runs();
    run_expect(8'h01, 8'hA6);
    run_expect(8'h04, 8'hA3);
    run_expect(8'h02, 8'hA5);
    run_expect(8'h08, 8'hA4);
    run_expect(8'h80, 8'hA7);
    run_expect(8'h10, 8'h02);
  endtask

  task automatic unsafe_run();
    stop_run(8'h20, 8'h00, 8'h03);
  endtask

  task automatic stop_run(input logic [7:0] f, input logic [7:0] h, input logic [7:0] code);
    logic [7:0] b [4];
    int n;
    if (h != 8'h00) begin
      wr(8'h02, h);
    end
    @(posedge core_clk);
    faults    <= f & 8'hDF;
    runSwitch <= 1'b1;
    wait_busy(1'b1);
    @(posedge core_clk);
    runSwitch <= 1'b0;
    n = 0;
    for (int k = 0; k < 3000 && n < 20; k++) begin
      @(negedge core_clk);
      n += driveCmd.read;
    end
    if (n < 20) timeout();
    chk("target", {driveCmd.head, driveCmd.cyl[7:0]}, {h, 8'h00});
    @(posedge core_clk);
    faults[5] <= f[5];
    runSwitch <= !f[5];
    wait_busy(1'b0);
    @(posedge core_clk);
    runSwitch <= 1'b0;
    faults    <= 8'h00;
    for (int i = 0; i < 4; i++) begin
      rd(8'h08 + 8'(i), b[i]);
    end
    chk("code", {8'h00, resultCode}, {8'h00, code});
    chk("tries", {15'h0000, {b[0], b[1]} != 16'h0000 && {b[0], b[1]} < 16'hFFED}, 16'h0001);
    chk("errs", f[6] ? {b[0], b[1]} + {b[2], b[3]} : {b[2], b[3]}, f[6] ? 16'hFFFF : 16'h0000);
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    reset_check();
    stop_run(8'h00, 8'h00, 8'hFF);
    param_runs();
    fault_runs();
    unsafe_run();
    wr(8'h04, 8'h1F);
    stop_run(8'h40, 8'h05, 8'h04);
    tally_and_finish();
  end
endmodule
